// file: hdl/sfe_pkg.sv
// constants and types for the procedure-entry frame builder
//
// Functional notes
// - frame setup takes a local byte count and a nesting depth.
// - nesting depth is accepted from 0 through 31.
// - nesting depth sets how many frame pointers get copied.
// - every frame pointer written or copied is one doubleword.
// - first display doubleword holds the previous frame pointer.
// - after the display, stack pointer drops by the local byte count.
// - frame base ends pointing at the first, highest display doubleword.
// - accesses based on the frame base default to the stack segment.
// - depth 0: push frame base, copy stack top to it, subtract count.
// - depth 0 copies no pointers; nonzero depth uses the nested form.
// - depth 1 copies nothing; pushes old base and new frame pointer, then reserves local storage.
// - depth causes no privilege check and no privilege change.
package sfe_pkg;

	// ----------------------------------------------------------------
	// widths and reset values
	// ----------------------------------------------------------------
	localparam int ADDR_W = 32;
	localparam int LEVEL_W = 5;
	localparam int STOR_W = 16;
	localparam logic [4:0] LEVEL_MAX = 5'h1F;
	localparam logic [31:0] WORD_BYTES = 32'h0000_0004;
	localparam logic [31:0] FBP_RST = 32'h0000_0000;
	localparam logic [31:0] STP_RST = 32'h0000_0000;

	// ----------------------------------------------------------------
	// sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_PUSH_OLD = 3'b001,
		S_READ = 3'b010,
		S_COPY = 3'b011,
		S_PUSH_NEW = 3'b100,
		S_ALLOC = 3'b101
	} sfe_state_t;

endpackage : sfe_pkg

// file: hdl/sfe_mem_if.sv
// request and answer carrier between sequencer and memory port
`timescale 1ns/10ps
interface sfe_mem_if;
	logic req;
	logic we;
	logic [31:0] addr;
	logic [31:0] wdata;
	logic rsp;
	logic [31:0] rdata;

	modport ctl (output req, output we, output addr, output wdata,
		input rsp, input rdata);
	modport mem (input req, input we, input addr, input wdata,
		output rsp, output rdata);
endinterface : sfe_mem_if

// file: hdl/sfe_mem_port.sv
// registered stack memory port: holds one access until acknowledged
`timescale 1ns/10ps
module sfe_mem_port (
	// clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// sequencer side
	sfe_mem_if.mem mif,
	// stack memory side
	output logic mem_req,
	output logic mem_we,
	output logic [31:0] mem_addr,
	output logic [31:0] mem_wdata,
	input wire logic mem_ack,
	input wire logic [31:0] mem_rdata
);

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			mem_req <= 1'b0;
			mem_we <= 1'b0;
			mem_addr <= 32'h0000_0000;
			mem_wdata <= 32'h0000_0000;
		end else if (mif.req) begin
			mem_req <= 1'b1;
			mem_we <= mif.we;
			mem_addr <= mif.addr;
			mem_wdata <= mif.wdata;
		end else if (mem_req && mem_ack) begin
			mem_req <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			mif.rsp <= 1'b0;
			mif.rdata <= 32'h0000_0000;
		end else begin
			mif.rsp <= mem_req && mem_ack;
			if (mem_req && mem_ack) begin
				mif.rdata <= mem_rdata;
			end
		end
	end

endmodule : sfe_mem_port

// file: hdl/sfe_enter.sv
// procedure-entry sequencer: builds a stack frame and display
`timescale 1ns/10ps
module sfe_enter (
	// clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// command
	input wire logic start,
	input wire logic [sfe_pkg::STOR_W-1:0] storage,
	input wire logic [sfe_pkg::LEVEL_W-1:0] level,
	output logic busy,
	output logic done,
	// pointer load while idle
	input wire logic load_en,
	input wire logic [31:0] load_fbp,
	input wire logic [31:0] load_stp,
	output logic [31:0] frame_base_pointer,
	output logic [31:0] stack_top_pointer,
	// segment default for an access being formed
	input wire logic base_is_fbp,
	output logic use_stack_seg,
	// stack memory
	output logic mem_req,
	output logic mem_we,
	output logic [31:0] mem_addr,
	output logic [31:0] mem_wdata,
	input wire logic mem_ack,
	input wire logic [31:0] mem_rdata
);

	sfe_mem_if mif ();

	sfe_pkg::sfe_state_t state_q;
	logic [4:0] lvl_q;
	logic [4:0] left_q;
	logic [4:0] rd_cnt_q;
	logic [15:0] stor_q;
	logic [31:0] start_sp_q;
	logic [31:0] start_bp_q;
	logic [31:0] walk_q;
	logic [31:0] frame_tmp_q;
	logic [31:0] copy_q;
	logic [31:0] fbp_q;
	logic [31:0] stp_q;
	logic pend_q;
	logic req_q;
	logic we_q;
	logic [31:0] addr_q;
	logic [31:0] wdata_q;
	logic acc_done;
	logic need_acc;

	assign acc_done = pend_q && mif.rsp;
	assign need_acc = (state_q == sfe_pkg::S_PUSH_OLD) ||
		(state_q == sfe_pkg::S_READ) || (state_q == sfe_pkg::S_COPY) ||
		(state_q == sfe_pkg::S_PUSH_NEW);

	assign mif.req = req_q;
	assign mif.we = we_q;
	assign mif.addr = addr_q;
	assign mif.wdata = wdata_q;
	assign frame_base_pointer = fbp_q;
	assign stack_top_pointer = stp_q;

	sfe_mem_port u_port (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.mif(mif.mem),
		.mem_req(mem_req),
		.mem_we(mem_we),
		.mem_addr(mem_addr),
		.mem_wdata(mem_wdata),
		.mem_ack(mem_ack),
		.mem_rdata(mem_rdata)
	);

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			state_q <= sfe_pkg::S_IDLE;
			lvl_q <= 5'h00;
			left_q <= 5'h00;
			rd_cnt_q <= 5'h00;
			stor_q <= 16'h0000;
			start_sp_q <= 32'h0000_0000;
			start_bp_q <= 32'h0000_0000;
			busy <= 1'b0;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			unique case (state_q)
				sfe_pkg::S_IDLE: begin
					if (start) begin
						// full 5-bit depth, no privilege input
						lvl_q <= level & sfe_pkg::LEVEL_MAX;
						left_q <= level - 5'h01;
						rd_cnt_q <= 5'h00;
						stor_q <= storage;
						start_sp_q <= stp_q;
						start_bp_q <= fbp_q;
						busy <= 1'b1;
						state_q <= sfe_pkg::S_PUSH_OLD;
					end
				end
				sfe_pkg::S_PUSH_OLD: begin
					if (acc_done) begin
						if (lvl_q == 5'h00) begin
							state_q <= sfe_pkg::S_ALLOC;
						end else if (left_q == 5'h00) begin
							state_q <= sfe_pkg::S_PUSH_NEW;
						end else begin
							state_q <= sfe_pkg::S_READ;
						end
					end
				end
				sfe_pkg::S_READ: begin
					if (acc_done) begin
						state_q <= sfe_pkg::S_COPY;
					end
				end
				sfe_pkg::S_COPY: begin
					if (acc_done) begin
						left_q <= left_q - 5'h01;
						rd_cnt_q <= rd_cnt_q + 5'h01;
						if (left_q == 5'h01) begin
							state_q <= sfe_pkg::S_PUSH_NEW;
						end else begin
							state_q <= sfe_pkg::S_READ;
						end
					end
				end
				sfe_pkg::S_PUSH_NEW: begin
					if (acc_done) begin
						state_q <= sfe_pkg::S_ALLOC;
					end
				end
				sfe_pkg::S_ALLOC: begin
					busy <= 1'b0;
					done <= 1'b1;
					state_q <= sfe_pkg::S_IDLE;
				end
				default: begin
					busy <= 1'b0;
					state_q <= sfe_pkg::S_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// memory requests, one doubleword each
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			pend_q <= 1'b0;
			req_q <= 1'b0;
			we_q <= 1'b0;
			addr_q <= 32'h0000_0000;
			wdata_q <= 32'h0000_0000;
		end else if (need_acc && !pend_q) begin
			pend_q <= 1'b1;
			req_q <= 1'b1;
			we_q <= (state_q != sfe_pkg::S_READ);
			if (state_q == sfe_pkg::S_READ) begin
				addr_q <= walk_q - sfe_pkg::WORD_BYTES;
			end else begin
				addr_q <= stp_q - sfe_pkg::WORD_BYTES;
			end
			unique case (state_q)
				sfe_pkg::S_PUSH_OLD: wdata_q <= fbp_q;
				sfe_pkg::S_COPY: wdata_q <= copy_q;
				sfe_pkg::S_PUSH_NEW: wdata_q <= frame_tmp_q;
				default: wdata_q <= 32'h0000_0000;
			endcase
		end else begin
			req_q <= 1'b0;
			if (acc_done) begin
				pend_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// frame base, stack top, display walk
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			fbp_q <= sfe_pkg::FBP_RST;
			stp_q <= sfe_pkg::STP_RST;
			walk_q <= 32'h0000_0000;
			frame_tmp_q <= 32'h0000_0000;
			copy_q <= 32'h0000_0000;
		end else begin
			if (state_q == sfe_pkg::S_IDLE && load_en && !start) begin
				fbp_q <= load_fbp;
				stp_q <= load_stp;
			end
			if (state_q == sfe_pkg::S_IDLE) begin
				walk_q <= fbp_q;
			end
			if (acc_done && state_q == sfe_pkg::S_PUSH_OLD) begin
				stp_q <= stp_q - sfe_pkg::WORD_BYTES;
				frame_tmp_q <= stp_q - sfe_pkg::WORD_BYTES;
				if (lvl_q == 5'h00) begin
					fbp_q <= stp_q - sfe_pkg::WORD_BYTES;
				end
			end
			if (acc_done && state_q == sfe_pkg::S_READ) begin
				walk_q <= walk_q - sfe_pkg::WORD_BYTES;
				copy_q <= mif.rdata;
			end
			if (acc_done && state_q == sfe_pkg::S_COPY) begin
				stp_q <= stp_q - sfe_pkg::WORD_BYTES;
			end
			if (acc_done && state_q == sfe_pkg::S_PUSH_NEW) begin
				stp_q <= stp_q - sfe_pkg::WORD_BYTES;
				fbp_q <= frame_tmp_q;
			end
			if (state_q == sfe_pkg::S_ALLOC) begin
				stp_q <= stp_q - {16'h0000, stor_q};
			end
		end
	end

	// ----------------------------------------------------------------
	// segment default
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			use_stack_seg <= 1'b0;
		end else begin
			use_stack_seg <= base_is_fbp;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);

	logic [5:0] pushes;
	assign pushes = (lvl_q == 5'h00) ? 6'h01 : {1'b0, lvl_q} + 6'h01;
	property p_start_taken;
		(state_q == sfe_pkg::S_IDLE && start) |=> busy ##0 !done;
	endproperty
	a_start_taken: assert property (p_start_taken)
		else $error("start not taken");
	property p_first_push;
		(req_q && state_q == sfe_pkg::S_PUSH_OLD) |->
			we_q && wdata_q == start_bp_q &&
			addr_q == start_sp_q - sfe_pkg::WORD_BYTES;
	endproperty
	a_first_push: assert property (p_first_push)
		else $error("old frame base not pushed first");
	property p_fbp_final;
		done |-> fbp_q == start_sp_q - sfe_pkg::WORD_BYTES;
	endproperty
	a_fbp_final: assert property (p_fbp_final)
		else $error("frame base wrong at completion");
	property p_stp_final;
		done |-> stp_q == start_sp_q - {24'h0, pushes, 2'b00} -
			{16'h0000, stor_q};
	endproperty
	a_stp_final: assert property (p_stp_final)
		else $error("stack top wrong at completion");
	property p_copy_count;
		done |-> rd_cnt_q == ((lvl_q > 5'h01) ? lvl_q - 5'h01 : 5'h00);
	endproperty
	a_copy_count: assert property (p_copy_count)
		else $error("display copy count wrong");
	property p_no_copy_low;
		(state_q == sfe_pkg::S_READ) |-> lvl_q > 5'h01;
	endproperty
	a_no_copy_low: assert property (p_no_copy_low)
		else $error("copy at depth 0 or 1");
	property p_walk_addr;
		(req_q && state_q == sfe_pkg::S_READ) |->
			!we_q && addr_q == start_bp_q - {25'h0, rd_cnt_q + 5'h01, 2'b00};
	endproperty
	a_walk_addr: assert property (p_walk_addr)
		else $error("display read address wrong");
	property p_new_push;
		(req_q && state_q == sfe_pkg::S_PUSH_NEW) |->
			wdata_q == start_sp_q - sfe_pkg::WORD_BYTES ##1 !done;
	endproperty
	a_new_push: assert property (p_new_push)
		else $error("latched frame address not pushed");
	property p_seg;
		base_is_fbp |=> use_stack_seg;
	endproperty
	a_seg: assert property (p_seg)
		else $error("stack segment default missing");

endmodule : sfe_enter

// file: tb/sfe_stack_mem.sv
// behavioural stack memory with a settable answer delay
`timescale 1ns/10ps
module sfe_stack_mem (
	// clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// access from the frame builder
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [31:0] mem_addr,
	input wire logic [31:0] mem_wdata,
	output logic mem_ack,
	output logic [31:0] mem_rdata,
	// wait cycles before each answer
	input wire logic [3:0] wait_cyc
);
	logic [31:0] store [logic [31:0]];
	logic [3:0] cnt_q;
	int rd_n;
	int wr_n;

	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			mem_ack <= 1'b0;
			cnt_q <= 4'h0;
			mem_rdata <= 32'h5A5A_A5A5;
		end else begin
			mem_ack <= 1'b0;
			// read data never lingers after its answer
			mem_rdata <= ~mem_rdata;
			if (mem_req && !mem_ack) begin
				cnt_q <= cnt_q + 4'h1;
				if (cnt_q == wait_cyc) begin
					cnt_q <= 4'h0;
					mem_ack <= 1'b1;
					if (!mem_we) begin
						mem_rdata <= store[mem_addr];
					end
				end
			end
			// access lands where request meets answer
			if (mem_req && mem_ack) begin
				if (mem_we) begin
					store[mem_addr] = mem_wdata;
					wr_n++;
				end else begin
					rd_n++;
				end
			end
		end
	end
endmodule : sfe_stack_mem

// file: tb/test_stack_frame_entry.sv
// self-checking bench for the procedure-entry frame builder
`timescale 1ns/10ps
module test_stack_frame_entry;
	logic clk_sys, nrst, start, busy, done, load_en;
	logic base_is_fbp, use_stack_seg, mem_req, mem_we, mem_ack;
	logic [sfe_pkg::STOR_W-1:0] storage;
	logic [sfe_pkg::LEVEL_W-1:0] level;
	logic [31:0] load_fbp, load_stp, frame_base_pointer, stack_top_pointer;
	logic [31:0] mem_addr, mem_wdata, mem_rdata;
	logic [3:0] wait_cyc;
	int failures;
	int cmp_count;
	int cycles;

	sfe_enter dut (.clk_sys, .nrst, .start, .storage, .level, .busy,
		.done, .load_en, .load_fbp, .load_stp, .frame_base_pointer,
		.stack_top_pointer, .base_is_fbp, .use_stack_seg, .mem_req,
		.mem_we, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata);
	sfe_stack_mem mem (.clk_sys, .nrst, .mem_req, .mem_we, .mem_addr,
		.mem_wdata, .mem_ack, .mem_rdata, .wait_cyc);

	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	task automatic wrap_up;
		$display("compares %0d failures %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : wrap_up

	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			$display("ERROR %0t run hung", $time);
			wrap_up();
		end
	end

	task automatic chk32(input logic [31:0] got, input logic [31:0] exp,
		input string what);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk32

	task automatic chk1(input logic got, input logic exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %0t %s got %b", $time, what, got);
		end
	endtask : chk1

	// one frame build; poke tries a second start while busy
	task automatic do_frame(input logic [15:0] st, input logic [4:0] lv,
		input logic [31:0] fb, input logic [31:0] sp, input logic [3:0] dl,
		input bit poke);
		logic [31:0] frm;
		logic [31:0] pat;
		int n;
		frm = sp - sfe_pkg::WORD_BYTES;
		mem.store.delete();
		mem.rd_n = 0;
		mem.wr_n = 0;
		for (int k = 1; k < lv; k++) begin
			pat = 32'hC0DE_0000 | 32'(k);
			mem.store[fb - 32'(4 * k)] = pat;
		end
		@(negedge clk_sys);
		wait_cyc = dl;
		load_en = 1'b1;
		load_fbp = fb;
		load_stp = sp;
		@(negedge clk_sys);
		load_en = 1'b0;
		start = 1'b1;
		storage = st;
		level = lv;
		n = 0;
		@(negedge clk_sys);
		start = 1'b0;
		chk1(busy, 1'b1, "busy on");
		while (done !== 1'b1 && n < 3000) begin
			start = poke && n == 3;
			@(negedge clk_sys);
			n++;
		end
		start = 1'b0;
		chk1(done, 1'b1, "done");
		chk1(busy, 1'b0, "busy");
		chk1(mem_req, 1'b0, "bus idle");
		chk32(frame_base_pointer, frm, "frame base");
		chk32(stack_top_pointer, frm - 32'(4 * lv) - 32'(st), "top");
		chk32(mem.store[frm], fb, "saved base");
		for (int k = 1; k < lv; k++) begin
			pat = 32'hC0DE_0000 | 32'(k);
			chk32(mem.store[frm - 32'(4 * k)], pat, "copy");
		end
		if (lv != 0) begin
			chk32(mem.store[frm - 32'(4 * lv)], frm, "frame");
		end
		chk32(32'(mem.rd_n), 32'(lv == 0 ? 0 : lv - 1), "reads");
		chk32(32'(mem.wr_n), 32'(lv == 0 ? 1 : lv + 1), "writes");
	endtask : do_frame

	task automatic t_flat;
		do_frame(16'h0010, 5'h00, 32'h8000, 32'h7F00, 4'h0, 1'b0);
	endtask : t_flat

	task automatic t_main;
		do_frame(16'h000C, 5'h01, 32'h9000, 32'h8F00, 4'h2, 1'b0);
	endtask : t_main

	task automatic t_nest;
		do_frame(16'h0800, 5'h03, 32'h10000, 32'hF000, 4'h1, 1'b1);
	endtask : t_nest

	task automatic t_deep;
		do_frame(16'hFFFF, 5'h1F, 32'h20000, 32'h1F000, 4'h3, 1'b0);
	endtask : t_deep

	task automatic t_seg;
		@(negedge clk_sys);
		base_is_fbp = 1'b1;
		@(negedge clk_sys);
		chk1(use_stack_seg, 1'b1, "seg on");
		base_is_fbp = 1'b0;
		@(negedge clk_sys);
		chk1(use_stack_seg, 1'b0, "seg off");
	endtask : t_seg

	initial begin
		nrst = 1'b0;
		{start, load_en, base_is_fbp} = 3'h0;
		storage = 16'h0000;
		level = 5'h00;
		load_fbp = 32'h0000_0000;
		load_stp = 32'h0000_0000;
		wait_cyc = 4'h0;
		failures = 0;
		cmp_count = 0;
		cycles = 0;
		repeat (12) @(posedge clk_sys);
		@(negedge clk_sys);
		chk32(frame_base_pointer, sfe_pkg::FBP_RST, "base reset");
		chk32(stack_top_pointer, sfe_pkg::STP_RST, "top reset");
		nrst = 1'b1;
		t_flat();
		t_main();
		t_nest();
		t_deep();
		t_seg();
		wrap_up();
	end
endmodule : test_stack_frame_entry
